// File: sdi_deser_idle_status_regs.sv
// idle character, gpio and status registers behind a two-wire management slave
// Functional notes
// - idle character fills stream when data invalid
// - idle resets to K28.5, software may rewrite
// - gpio pins follow last written bits
// - status bit 5 shows loop-through enable
// - loop-through status resets to 0, then follows sampled pin
// - mode field: 11 means ASI, else video
// - variant register read returns eight-bit value
// - fixed two-bit part type code in variant
`timescale 1ns/1ns
`default_nettype none
module sdi_deser_idle_status_regs (
   input  wire logic                   REF_CLK,
   input  wire logic                   NRST,
   input  wire logic                   SCL_IN,
   input  wire logic                   SDA_IN,
   output logic                        SDA_OUT,
   output logic                        SDA_OE,
   input  wire logic                   LOOP_EN_PIN,
   input  wire logic [1:0]             MODE_IN,
   input  wire sdi_idle_pkg::word_type RX_WORD,
   output sdi_idle_pkg::word_type      TX_WORD,
   output logic [1:0]                  GPIO,
   output logic                        LOOP_EN,
   output logic                        ASI_MODE
);

   logic                        scl_m_r;
   logic                        scl_s_r;
   logic                        scl_d_r;
   logic                        sda_m_r;
   logic                        sda_s_r;
   logic                        sda_d_r;
   logic                        loop_m_r;
   logic                        loop_s_r;
   logic                        loop_r;
   logic                        loop_seen_r;
   logic [7:0]                  idle_low_r;
   logic [1:0]                  idle_high_r;
   logic [1:0]                  gpio_r;
   sdi_idle_pkg::bus_state_type state_r;
   logic [3:0]                  bit_cnt_r;
   logic [7:0]                  shift_r;
   logic [7:0]                  ptr_r;
   logic                        oe_r;
   logic                        got_ack_r;
   logic                        scl_rise;
   logic                        scl_fall;
   logic                        start_cond;
   logic                        stop_cond;
   logic                        wr_en;
   logic [7:0]                  rd_data;
   logic [9:0]                  idle_char;

   // register read decode, shared by the first and following read bytes
   function automatic logic [7:0] reg_read(input logic [7:0] ofs, input logic [7:0] low, input logic [1:0] high,
                                           input logic [1:0] gp, input logic loop, input logic [1:0] mode);
      logic [7:0] v;
      v = sdi_idle_pkg::RST_READ;
      case (ofs)
         sdi_idle_pkg::OFS_GPIO: begin
            v[sdi_idle_pkg::POS_GPIO1] = gp[1];
            v[sdi_idle_pkg::POS_GPIO0] = gp[0];
         end
         sdi_idle_pkg::OFS_IDLE_LOW: begin
            v = low;
         end
         sdi_idle_pkg::OFS_IDLE_HIGH: begin
            v[1:0] = high;
         end
         sdi_idle_pkg::OFS_VARIANT: begin
            v[sdi_idle_pkg::POS_LOOP] = loop;
            v[sdi_idle_pkg::POS_MODE_LO +: 2] = mode;
            v[sdi_idle_pkg::POS_PART_LO +: 2] = sdi_idle_pkg::PART_CODE;
         end
         default: begin
            v = sdi_idle_pkg::RST_READ;
         end
      endcase
      return v;
   endfunction

   // bus and loop pins cross into the core clock through two flops each; MODE_IN is used unsynchronised
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         scl_m_r  <= 1'b1;
         scl_s_r  <= 1'b1;
         scl_d_r  <= 1'b1;
         sda_m_r  <= 1'b1;
         sda_s_r  <= 1'b1;
         sda_d_r  <= 1'b1;
         loop_m_r <= 1'b0;
         loop_s_r <= 1'b0;
      end else begin
         scl_m_r  <= SCL_IN;
         scl_s_r  <= scl_m_r;
         scl_d_r  <= scl_s_r;
         sda_m_r  <= SDA_IN;
         sda_s_r  <= sda_m_r;
         sda_d_r  <= sda_s_r;
         loop_m_r <= LOOP_EN_PIN;
         loop_s_r <= loop_m_r;
      end
   end

   // pin level is only known once the synchroniser has filled after release
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         loop_seen_r <= 1'b0;
         loop_r      <= 1'b0;
      end else begin
         loop_seen_r <= 1'b1;
         if (loop_seen_r) begin
            loop_r <= loop_s_r;
         end
      end
   end

   assign scl_rise   = scl_s_r & ~scl_d_r;
   assign scl_fall   = ~scl_s_r & scl_d_r;
   assign start_cond = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
   assign stop_cond  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
   assign wr_en      = scl_fall && (state_r == sdi_idle_pkg::ST_WDATA) && (bit_cnt_r == sdi_idle_pkg::BYTE_BITS);
   assign rd_data    = reg_read(ptr_r, idle_low_r, idle_high_r, gpio_r, loop_r, MODE_IN);

   // writable registers; reserved and read-only offsets ignore writes
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         idle_low_r  <= sdi_idle_pkg::RST_IDLE_LOW;
         idle_high_r <= sdi_idle_pkg::RST_IDLE_HIGH;
         gpio_r      <= sdi_idle_pkg::RST_GPIO;
      end else if (wr_en) begin
         case (ptr_r)
            sdi_idle_pkg::OFS_GPIO: begin
               gpio_r <= {shift_r[sdi_idle_pkg::POS_GPIO1], shift_r[sdi_idle_pkg::POS_GPIO0]};
            end
            sdi_idle_pkg::OFS_IDLE_LOW: begin
               idle_low_r <= shift_r;
            end
            sdi_idle_pkg::OFS_IDLE_HIGH: begin
               idle_high_r <= shift_r[1:0];
            end
            default: begin
               gpio_r <= gpio_r;
            end
         endcase
      end
   end

   // management slave: bits sampled on scl rise, sda changed on scl fall
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         state_r   <= sdi_idle_pkg::ST_IDLE;
         bit_cnt_r <= 4'h0;
         shift_r   <= 8'h00;
         ptr_r     <= 8'h00;
         oe_r      <= 1'b0;
         got_ack_r <= 1'b0;
      end else if (start_cond) begin
         state_r   <= sdi_idle_pkg::ST_ADDR;
         bit_cnt_r <= 4'h0;
         oe_r      <= 1'b0;
      end else if (stop_cond) begin
         state_r <= sdi_idle_pkg::ST_IDLE;
         oe_r    <= 1'b0;
      end else begin
         case (state_r)
            sdi_idle_pkg::ST_ADDR, sdi_idle_pkg::ST_REG, sdi_idle_pkg::ST_WDATA: begin
               if (scl_rise && bit_cnt_r != sdi_idle_pkg::BYTE_BITS) begin
                  shift_r   <= {shift_r[6:0], sda_s_r};
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end else if (scl_fall && bit_cnt_r == sdi_idle_pkg::BYTE_BITS) begin
                  bit_cnt_r <= 4'h0;
                  oe_r      <= 1'b1;
                  if (state_r == sdi_idle_pkg::ST_ADDR) begin
                     if (shift_r[7:1] == sdi_idle_pkg::DEV_ADDR) begin
                        got_ack_r <= shift_r[0];
                        state_r   <= sdi_idle_pkg::ST_ADDR_ACK;
                     end else begin
                        // not our address: stay off the line until the next start
                        oe_r    <= 1'b0;
                        state_r <= sdi_idle_pkg::ST_IDLE;
                     end
                  end else if (state_r == sdi_idle_pkg::ST_REG) begin
                     ptr_r   <= shift_r;
                     state_r <= sdi_idle_pkg::ST_REG_ACK;
                  end else begin
                     ptr_r   <= ptr_r + 8'h01;
                     state_r <= sdi_idle_pkg::ST_WDATA_ACK;
                  end
               end
            end
            sdi_idle_pkg::ST_ADDR_ACK: begin
               if (scl_fall) begin
                  if (got_ack_r) begin
                     shift_r <= rd_data;
                     oe_r    <= ~rd_data[7];
                     ptr_r   <= ptr_r + 8'h01;
                     state_r <= sdi_idle_pkg::ST_RDATA;
                  end else begin
                     oe_r    <= 1'b0;
                     state_r <= sdi_idle_pkg::ST_REG;
                  end
               end
            end
            sdi_idle_pkg::ST_REG_ACK, sdi_idle_pkg::ST_WDATA_ACK: begin
               if (scl_fall) begin
                  oe_r    <= 1'b0;
                  state_r <= sdi_idle_pkg::ST_WDATA;
               end
            end
            sdi_idle_pkg::ST_RDATA: begin
               if (scl_rise) begin
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end else if (scl_fall) begin
                  if (bit_cnt_r == sdi_idle_pkg::BYTE_BITS) begin
                     oe_r      <= 1'b0;
                     bit_cnt_r <= 4'h0;
                     state_r   <= sdi_idle_pkg::ST_RDATA_ACK;
                  end else begin
                     shift_r <= {shift_r[6:0], 1'b0};
                     oe_r    <= ~shift_r[6];
                  end
               end
            end
            sdi_idle_pkg::ST_RDATA_ACK: begin
               if (scl_rise) begin
                  got_ack_r <= ~sda_s_r;
               end else if (scl_fall) begin
                  if (got_ack_r) begin
                     shift_r <= rd_data;
                     oe_r    <= ~rd_data[7];
                     ptr_r   <= ptr_r + 8'h01;
                     state_r <= sdi_idle_pkg::ST_RDATA;
                  end else begin
                     state_r <= sdi_idle_pkg::ST_IDLE;
                  end
               end
            end
            default: begin
               oe_r <= 1'b0;
            end
         endcase
      end
   end

   assign idle_char = {idle_high_r, idle_low_r};

   idle_inserter u_fill (
      .clk       (REF_CLK),
      .nrst      (NRST),
      .word_in   (RX_WORD),
      .idle_char (idle_char),
      .word_out  (TX_WORD)
   );

   // open drain: only ever pulls low
   assign SDA_OUT  = 1'b0;
   assign SDA_OE   = oe_r;
   assign GPIO     = gpio_r;
   assign LOOP_EN  = loop_r;
   assign ASI_MODE = (MODE_IN == sdi_idle_pkg::MODE_ASI);

endmodule
`default_nettype wire

// File: sdi_idle_pkg.sv
// shared constants and types for the idle and status register slice
`default_nettype none
package sdi_idle_pkg;

   // management bus slave address, arbitrary value
   localparam logic [6:0] DEV_ADDR        = 7'h2C;

   // register offsets
   localparam logic [7:0] OFS_GPIO        = 8'h0C;
   localparam logic [7:0] OFS_IDLE_LOW    = 8'h0D;
   localparam logic [7:0] OFS_IDLE_HIGH   = 8'h0E;
   localparam logic [7:0] OFS_RSVD_FIRST  = 8'h0F;
   localparam logic [7:0] OFS_RSVD_LAST   = 8'h1C;
   localparam logic [7:0] OFS_VARIANT     = 8'h1D;

   // reset values
   localparam logic [7:0] RST_IDLE_LOW    = 8'h83;
   localparam logic [1:0] RST_IDLE_HIGH   = 2'h2;
   localparam logic [1:0] RST_GPIO        = 2'h0;
   localparam logic [7:0] RST_READ        = 8'h00;

   // field positions
   localparam int         POS_GPIO1       = 1;
   localparam int         POS_GPIO0       = 0;
   localparam int         POS_LOOP        = 5;
   localparam int         POS_MODE_LO     = 3;
   localparam int         POS_PART_LO     = 0;

   // part type code, arbitrary value
   localparam logic [1:0] PART_CODE       = 2'h3;

   // bit count of one management byte
   localparam logic [3:0] BYTE_BITS       = 4'h8;

   typedef enum logic [1:0] {
      MODE_VIDEO_A = 2'b00,
      MODE_VIDEO_B = 2'b01,
      MODE_VIDEO_C = 2'b10,
      MODE_ASI     = 2'b11
   } mode_type;

   typedef enum logic [3:0] {
      ST_IDLE      = 4'b0000,
      ST_ADDR      = 4'b0001,
      ST_ADDR_ACK  = 4'b0010,
      ST_REG       = 4'b0011,
      ST_REG_ACK   = 4'b0100,
      ST_WDATA     = 4'b0101,
      ST_WDATA_ACK = 4'b0110,
      ST_RDATA     = 4'b0111,
      ST_RDATA_ACK = 4'b1000
   } bus_state_type;

   // one 10-bit character with its valid mark
   typedef struct packed {
      logic       valid;
      logic [9:0] data;
   } word_type;

endpackage
`default_nettype wire

// File: idle_inserter.sv
// substitutes the idle character into the output stream when no data is valid
`timescale 1ns/1ns
`default_nettype none
module idle_inserter (
   input  wire logic                  clk,
   input  wire logic                  nrst,
   input  wire sdi_idle_pkg::word_type word_in,
   input  wire logic [9:0]            idle_char,
   output var  sdi_idle_pkg::word_type word_out
);

   // output is valid from the first clock after reset: either payload or the idle fill
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         word_out <= '0;
      end else begin
         word_out.valid <= 1'b1;
         word_out.data  <= word_in.valid ? word_in.data : idle_char;
      end
   end

endmodule
`default_nettype wire

// File: sdi_deser_idle_status_regs_monitor.sv
// port assertions for the idle character and status register slice
`timescale 1ns/1ns
`default_nettype none
module regs_monitor (
   input wire logic                   REF_CLK,
   input wire logic                   NRST,
   input wire logic                   SCL_IN,
   input wire logic                   SDA_OE,
   input wire logic                   LOOP_EN_PIN,
   input wire logic [1:0]             MODE_IN,
   input wire sdi_idle_pkg::word_type RX_WORD,
   input wire sdi_idle_pkg::word_type TX_WORD,
   input wire logic [1:0]             GPIO,
   input wire logic                   LOOP_EN,
   input wire logic                   ASI_MODE
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!NRST);
   tx_valid_a: assert property ($past(NRST) |-> TX_WORD.valid)
      else $error("stream word not marked valid");
   tx_pass_a: assert property (RX_WORD.valid |=> TX_WORD.data == $past(RX_WORD.data))
      else $error("valid payload not passed through");
   // bus quiet for eight cycles means no register write can still be in flight
   idle_hold_a: assert property ((SCL_IN && !RX_WORD.valid)[*8] |=> $stable(TX_WORD.data))
      else $error("idle character moved without a write");
   gpio_hold_a: assert property (SCL_IN[*8] |=> $stable(GPIO))
      else $error("gpio moved while bus quiet");
   gpio_time_a: assert property ($changed(GPIO) |-> !SCL_IN)
      else $error("gpio moved outside a clock low phase");
   loop_follow_a: assert property ($stable(LOOP_EN_PIN)[*6] |-> LOOP_EN == LOOP_EN_PIN)
      else $error("loop status does not follow pin");
   asi_mode_a: assert property (ASI_MODE == (MODE_IN == 2'b11))
      else $error("mode decode wrong");
   oe_time_a: assert property ($changed(SDA_OE) |-> !SCL_IN)
      else $error("data line changed while clock high");
endmodule
bind sdi_deser_idle_status_regs regs_monitor mon_u (.REF_CLK(REF_CLK), .NRST(NRST), .SCL_IN(SCL_IN),
   .SDA_OE(SDA_OE), .LOOP_EN_PIN(LOOP_EN_PIN), .MODE_IN(MODE_IN), .RX_WORD(RX_WORD),
   .TX_WORD(TX_WORD), .GPIO(GPIO), .LOOP_EN(LOOP_EN), .ASI_MODE(ASI_MODE));
`default_nettype wire

// File: smb_master_model.sv
// two-wire management master model facing the slave pins
`timescale 1ns/1ns
`default_nettype none
module smb_master_model (
   input  wire logic REF_CLK,
   input  wire logic SDA_LVL,
   output var  logic SCL,
   output var  logic SDA_LOW
);
   initial begin
      SCL = 1'b1;
      SDA_LOW = 1'b0;
   end
   task tick(input int n);
      repeat (n) @(posedge REF_CLK);
      #2;
   endtask
   // hold and setup of five cycles each, above the synced slave's three
   task bit_x(input logic b, output logic r);
      tick(5);
      SDA_LOW = !b;
      tick(5);
      SCL = 1'b1;
      tick(3);
      r = SDA_LVL;
      tick(3);
      SCL = 1'b0;
   endtask
   task start_c;
      tick(5);
      SDA_LOW = 1'b0;
      tick(5);
      SCL = 1'b1;
      tick(6);
      SDA_LOW = 1'b1;
      tick(6);
      SCL = 1'b0;
   endtask
   task stop_c;
      tick(5);
      SDA_LOW = 1'b1;
      tick(5);
      SCL = 1'b1;
      tick(6);
      SDA_LOW = 1'b0;
      tick(6);
   endtask
   task byte_x(input logic [7:0] d, input logic a_in, output logic [7:0] q, output logic a_out);
      for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
      bit_x(a_in, a_out);
   endtask
endmodule
`default_nettype wire

// File: testbench.sv
// self-checking bench for the idle character and status register slice
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic                   ref_clk = 1'b0;
   logic                   nrst = 1'b0;
   logic                   loop_pin = 1'b1;
   logic [1:0]             mode = 2'b00;
   sdi_idle_pkg::word_type rx = '0;
   sdi_idle_pkg::word_type tx;
   sdi_idle_pkg::word_type rx_seen;
   logic                   scl, m_low, sda_oe, sda_out, loop_en, asi, live, busy;
   logic [1:0]             gpio;
   logic [9:0]             idle_m = 10'h283;
   logic [7:0]             wq[$];
   logic [7:0]             rq[$];
   int                     fail_count = 0;
   int                     cmp_count = 0;
   int                     cyc = 0;
   integer                 seed = 32'h63EC;
   // open drain with pull-up: the slave's level only shows while its enable is up
   wire logic              sda = !m_low && (sda_oe ? sda_out : 1'b1);
   always #25 ref_clk = !ref_clk;
   sdi_deser_idle_status_regs dut_u (.REF_CLK(ref_clk), .NRST(nrst), .SCL_IN(scl), .SDA_IN(sda),
      .SDA_OUT(sda_out), .SDA_OE(sda_oe), .LOOP_EN_PIN(loop_pin), .MODE_IN(mode), .RX_WORD(rx),
      .TX_WORD(tx), .GPIO(gpio), .LOOP_EN(loop_en), .ASI_MODE(asi));
   smb_master_model master_u (.REF_CLK(ref_clk), .SDA_LVL(sda), .SCL(scl), .SDA_LOW(m_low));
   task chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      rx_seen <= rx;
      live <= nrst;
      cyc++;
      #2;
      rx = 11'($random(seed));
      // ceiling well above the roughly 14000 cycles the scenarios take
      if (cyc == 40000) begin
         fail_count++;
         wrap_up;
      end
   end
   always @(negedge ref_clk) begin
      if (live && !busy) chk(16'(tx), 16'({1'b1, rx_seen.valid ? rx_seen.data : idle_m}));
   end
   task wr(input logic [6:0] a, input logic [7:0] r);
      logic [7:0] q;
      logic [7:0] p;
      logic       k;
      busy = 1'b1;
      p = r;
      master_u.start_c;
      master_u.byte_x({a, 1'b0}, 1'b1, q, k);
      chk(16'(k), 16'(a != sdi_idle_pkg::DEV_ADDR));
      if (!k) begin
         master_u.byte_x(r, 1'b1, q, k);
         foreach (wq[i]) begin
            master_u.byte_x(wq[i], 1'b1, q, k);
            if (p == 8'h0D) idle_m[7:0] = wq[i];
            if (p == 8'h0E) idle_m[9:8] = wq[i][1:0];
            p++;
         end
      end
      master_u.stop_c;
      busy = 1'b0;
   endtask
   task rd(input logic [7:0] r, input int n);
      logic [7:0] q;
      logic       k;
      rq = {};
      master_u.start_c;
      master_u.byte_x({sdi_idle_pkg::DEV_ADDR, 1'b0}, 1'b1, q, k);
      master_u.byte_x(r, 1'b1, q, k);
      master_u.start_c;
      master_u.byte_x({sdi_idle_pkg::DEV_ADDR, 1'b1}, 1'b1, q, k);
      for (int i = 0; i < n; i++) begin
         master_u.byte_x(8'hFF, i == n - 1, q, k);
         rq.push_back(q);
      end
      master_u.stop_c;
   endtask
   initial begin
      busy = 1'b0;
      repeat (2) @(posedge ref_clk);
      #2;
      nrst = 1'b1;
      rd(8'h0D, 3);
      chk(16'(rq[0]), 16'h0083);
      chk(16'(rq[1]), 16'h0002);
      chk(16'(rq[2]), 16'h0000);
      chk(16'(loop_en), 16'(loop_pin));
      // gpio, low and high halves in one burst, then read back both halves
      for (int j = 0; j < 3; j++) begin
         wq = {8'($random(seed)), 8'($random(seed)), 8'($random(seed))};
         wr(sdi_idle_pkg::DEV_ADDR, 8'h0C);
         chk(16'(gpio), 16'(wq[0][1:0]));
         rd(8'h0C, 3);
         chk(16'(rq[0]), 16'({6'h00, wq[0][1:0]}));
         chk(16'(rq[1]), 16'(wq[1]));
         chk(16'(rq[2]), 16'({6'h00, wq[2][1:0]}));
      end
      wq = {8'hA5};
      wr(7'h2D, 8'h0D);
      rd(8'h0D, 1);
      chk(16'(rq[0]), 16'(idle_m[7:0]));
      wq = {8'hFF};
      wr(sdi_idle_pkg::DEV_ADDR, 8'h0F);
      rd(8'h0F, 1);
      chk(16'(rq[0]), 16'h0000);
      for (int j = 0; j < 8; j++) begin
         mode = j[1:0];
         loop_pin = j[2];
         rd(8'h1D, 1);
         chk(16'(rq[0]), 16'({2'b00, loop_pin, mode, 1'b0, sdi_idle_pkg::PART_CODE}));
         chk(16'(loop_en), 16'(loop_pin));
         chk(16'(asi), 16'(mode == 2'b11));
      end
      // second reset mid-run: written values must give way to reset values
      busy = 1'b1;
      nrst = 1'b0;
      repeat (2) @(posedge ref_clk);
      #2;
      nrst = 1'b1;
      idle_m = 10'h283;
      busy = 1'b0;
      chk(16'(gpio), 16'(sdi_idle_pkg::RST_GPIO));
      rd(8'h0D, 2);
      chk(16'(rq[0]), 16'(sdi_idle_pkg::RST_IDLE_LOW));
      chk(16'(rq[1]), 16'({6'h00, sdi_idle_pkg::RST_IDLE_HIGH}));
      chk(16'(loop_en), 16'(loop_pin));
      wrap_up;
   end
endmodule
`default_nettype wire
